// >>> logic/fspe_regs.svh
// Register offsets, field positions, reset values and timing counts of the self-program entry gate
`ifndef FSPE_REGS_SVH
`define FSPE_REGS_SVH

`define FSPE_OFF_CMD        8'h00
`define FSPE_OFF_MODE       8'h04
`define FSPE_OFF_STAT       8'h08
`define FSPE_OFF_RESULT     8'h0C

`define FSPE_MODE_WED_BIT   3
`define FSPE_MODE_VPP_BIT   2
`define FSPE_MODE_SPM_BIT   1
`define FSPE_MODE_ONE_BIT   4

`define FSPE_STAT_PERR_BIT  0
`define FSPE_STAT_BUSY_BIT  1
`define FSPE_STAT_WAIT_BIT  2
`define FSPE_STAT_NMI_BIT   3

`define FSPE_RST_WED        1'b1
`define FSPE_RST_SPM        1'b0

`define FSPE_TRAP_VEC       5'h1F
`define FSPE_NMI_OFS        32'h0000_0004
`define FSPE_NMI_DATA       8'h80

`define FSPE_CLK_PERIOD_NS  50
`define FSPE_SETTLE_US      100
`define FSPE_SETTLE_CYC     ((`FSPE_SETTLE_US * 1000 + `FSPE_CLK_PERIOD_NS - 1) / `FSPE_CLK_PERIOD_NS)
`define FSPE_CNT_W          12

`endif

// >>> logic/fspe_pkg.sv
// Types shared by the self-program entry gate and its settle counter
package fspe_pkg;

   typedef enum logic [1:0] {FSPE_IDLE, FSPE_BUSY, FSPE_DONE} fspe_state_e;

   typedef struct packed {
      logic [11:0] cnt;
   } fspe_cnt_s;

   typedef struct packed {
      logic [31:0] rdata;
      logic        unlock;
      logic        perr;
      logic        wed;
      logic        spm;
      logic        vpp_s1;
      logic        vpp_s2;
      fspe_state_e state;
      logic        nmi_seen;
      logic [31:0] arg_func;
      logic [31:0] arg_2;
      logic [31:0] arg_3;
      logic [31:0] arg_4;
      logic [31:0] arg_ep;
      logic [31:0] result;
      logic        start;
      logic        r10_we;
      logic        mem_we;
      logic        ret;
   } fspe_state_s;

endpackage

// >>> logic/fspe_settle_cnt.sv
// Down-counter that holds off flash access for the settle time after leaving self-programming
`timescale 1ns/10ps
`include "fspe_regs.svh"

module fspe_settle_cnt
(
   // Clock and reset
   input  wire logic i_mclk,
   input  wire logic i_arst_n,
   input  wire logic i_clk_en,
   // Control
   input  wire logic i_start,
   // Status
   output logic      o_busy
);
   import fspe_pkg::*;

   fspe_cnt_s st_r;
   fspe_cnt_s st_nxt;

   always_comb
   begin
      st_nxt = st_r;
      if (i_start)
      begin
         st_nxt.cnt = `FSPE_CNT_W'(`FSPE_SETTLE_CYC); // RL20
      end
      else if (st_r.cnt != '0)
      begin
         st_nxt.cnt = st_r.cnt - 12'h001;
      end
   end

   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         st_r <= '0;
      end
      else if (i_clk_en)
      begin
         st_r <= st_nxt;
      end
   end

   assign o_busy = (st_r.cnt != '0); // RL13

endmodule // fspe_settle_cnt

// >>> logic/fspe_top.sv
// Self-programming entry gate: protected mode register, trap steering, call and return handling
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/10ps
`include "fspe_regs.svh"

// Contract
// RL1: Write-enabled self-program mode plus trap 0x1f hands control to internal processing.
// RL2: Trap 0x1f stays an ordinary trap unless self-program mode is selected.
// RL3: Call reads function from r6, arguments r7 to r9, parameter block from ep.
// RL4: Completion places a 4-byte result in r10 before returning.
// RL5: NMI during processing sets bit 7 of byte at ep+4, else untouched.
// RL6: Software clears the NMI flag before each call and checks it after.
// RL7: NMI during hand-over may be lost; only the flag reports it.
// RL8: Before the trap software clears only the NMI-disable bit if needed.
// RL9: After return software masks all interrupts before touching the mode register.
// RL10: Each mode register write must directly follow a command register write.
// RL11: Leaving self-programming writes write/erase disabled and normal mode.
// RL12: Software runs five no-ops after changing the self-program select bit.
// RL13: No flash access until 100 us after returning to normal mode.
// RL14: DMA stops before any protected register access.
// RL15: Entry program runs outside block 0 and outside flash.
// RL16: Mode register: bit 3 write/erase disable, bit 2 voltage detect, bit 1 select.
// RL17: Bit 2 is read-only and shows programming voltage reached.
// RL18: Self-program select is ignored without programming voltage.
// RL19: Interrupt or DMA taken between command and mode write drops the write.
// RL20: A clock-scaled counter blocks flash for the settle time.
// RL21: Any access between command write and mode write cancels the unlock.

module fspe_top
(
   // Clock, reset, enable
   input  wire logic        i_mclk,
   input  wire logic        i_arst_n,
   input  wire logic        i_clk_en,
   // APB slave
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic [31:0]      o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   // Programming voltage detect pin
   input  wire logic        i_vpp_det,
   // CPU trap and interrupt acknowledge
   input  wire logic        i_trap_req,
   input  wire logic [4:0]  i_trap_vec,
   input  wire logic        i_int_ack,
   input  wire logic        i_dma_ack,
   input  wire logic        i_nmi,
   output logic             o_trap_internal,
   output logic             o_trap_ordinary,
   output logic             o_nmi_pass,
   // CPU argument registers
   input  wire logic [31:0] i_r6,
   input  wire logic [31:0] i_r7,
   input  wire logic [31:0] i_r8,
   input  wire logic [31:0] i_r9,
   input  wire logic [31:0] i_ep,
   // Internal processing engine
   output logic             o_proc_start,
   output logic [31:0]      o_proc_func,
   output logic [31:0]      o_proc_arg2,
   output logic [31:0]      o_proc_arg3,
   output logic [31:0]      o_proc_arg4,
   output logic [31:0]      o_proc_ep,
   input  wire logic        i_proc_done,
   input  wire logic [31:0] i_proc_result,
   // Return to CPU
   output logic             o_r10_we,
   output logic [31:0]      o_r10_data,
   output logic             o_mem_we,
   output logic [31:0]      o_mem_addr,
   output logic [7:0]       o_mem_set,
   output logic             o_return,
   // Flash array control
   output logic             o_self_prog,
   output logic             o_write_erase_en,
   output logic             o_flash_hold
);
   import fspe_pkg::*;

   fspe_state_s st_r;
   fspe_state_s st_nxt;

   logic        settle_busy;
   logic        settle_start;
   logic        spm_eff;
   logic        wr_acc;
   logic        rd_setup;
   logic        acc_done;
   logic        hit;
   logic        trap_hit;
   logic [7:0]  mode_rd;
   logic [31:0] stat_rd;

   // Selection is only honoured while the programming voltage stands
   assign spm_eff  = st_r.spm & st_r.vpp_s2; // RL18
   assign acc_done = i_psel & i_penable & i_clk_en;
   assign wr_acc   = acc_done & i_pwrite;
   assign rd_setup = i_psel & ~i_penable & ~i_pwrite;
   assign hit      = (i_paddr == `FSPE_OFF_CMD) | (i_paddr == `FSPE_OFF_MODE) |
                     (i_paddr == `FSPE_OFF_STAT) | (i_paddr == `FSPE_OFF_RESULT);

   // Internal hand-over needs mode selected, write/erase enabled and an idle engine
   assign trap_hit = i_trap_req & (i_trap_vec == `FSPE_TRAP_VEC) & spm_eff & ~st_r.wed &
                     (st_r.state == FSPE_IDLE); // RL1

   always_comb
   begin
      mode_rd = 8'h00;
      mode_rd[`FSPE_MODE_ONE_BIT] = 1'b1;
      mode_rd[`FSPE_MODE_WED_BIT] = st_r.wed;
      mode_rd[`FSPE_MODE_VPP_BIT] = st_r.vpp_s2; // RL17
      mode_rd[`FSPE_MODE_SPM_BIT] = st_r.spm;
   end

   always_comb
   begin
      stat_rd = 32'h0000_0000;
      stat_rd[`FSPE_STAT_PERR_BIT] = st_r.perr;
      stat_rd[`FSPE_STAT_BUSY_BIT] = (st_r.state != FSPE_IDLE);
      stat_rd[`FSPE_STAT_WAIT_BIT] = settle_busy;
      stat_rd[`FSPE_STAT_NMI_BIT]  = st_r.nmi_seen;
   end

   always_comb
   begin
      st_nxt        = st_r;
      settle_start  = 1'b0;
      st_nxt.vpp_s1 = i_vpp_det;
      st_nxt.vpp_s2 = st_r.vpp_s1;
      st_nxt.start  = 1'b0;
      st_nxt.r10_we = 1'b0;
      st_nxt.mem_we = 1'b0;
      st_nxt.ret    = 1'b0;

      // Read data is captured in the setup cycle so that it leaves a flop
      if (rd_setup)
      begin
         unique case (i_paddr)
            `FSPE_OFF_MODE:   st_nxt.rdata = {24'h000000, mode_rd};
            `FSPE_OFF_STAT:   st_nxt.rdata = stat_rd;
            `FSPE_OFF_RESULT: st_nxt.rdata = st_r.result;
            default:          st_nxt.rdata = 32'h0000_0000;
         endcase
      end

      // Any completed access other than the command write spends the unlock
      if (acc_done)
      begin
         st_nxt.unlock = 1'b0; // RL21
      end

      if (wr_acc && (i_paddr == `FSPE_OFF_CMD))
      begin
         st_nxt.unlock = 1'b1; // RL10
      end
      else if (wr_acc && (i_paddr == `FSPE_OFF_MODE))
      begin
         if (st_r.unlock)
         begin
            st_nxt.wed = i_pwdata[`FSPE_MODE_WED_BIT]; // RL16
            st_nxt.spm = i_pwdata[`FSPE_MODE_SPM_BIT] & st_r.vpp_s2; // RL18
            if (spm_eff && !(i_pwdata[`FSPE_MODE_SPM_BIT] & st_r.vpp_s2))
            begin
               settle_start = 1'b1; // RL13
            end
         end
         else
         begin
            st_nxt.perr = 1'b1; // RL19
         end
      end
      else if (wr_acc && (i_paddr == `FSPE_OFF_STAT) && i_pwdata[`FSPE_STAT_PERR_BIT])
      begin
         st_nxt.perr = 1'b0;
      end

      // An acknowledged interrupt or DMA cancels the pending unlock
      if ((i_int_ack || i_dma_ack) && st_r.unlock)
      begin
         st_nxt.unlock = 1'b0; // RL19
      end

      // Voltage falling away drops the mode just like a write would; only the second sync stage is read
      if (st_r.spm && !st_r.vpp_s2)
      begin
         st_nxt.spm   = 1'b0;
         settle_start = 1'b1; // RL13
      end

      unique case (st_r.state)
         FSPE_IDLE:
         begin
            if (trap_hit)
            begin
               st_nxt.arg_func = i_r6; // RL3
               st_nxt.arg_2    = i_r7;
               st_nxt.arg_3    = i_r8;
               st_nxt.arg_4    = i_r9;
               st_nxt.arg_ep   = i_ep;
               st_nxt.nmi_seen = i_nmi; // RL7
               st_nxt.start    = 1'b1;
               st_nxt.state    = FSPE_BUSY;
            end
         end
         FSPE_BUSY:
         begin
            if (i_nmi)
            begin
               st_nxt.nmi_seen = 1'b1; // RL5
            end
            if (i_proc_done && !st_r.start)
            begin
               st_nxt.result = i_proc_result; // RL4
               st_nxt.r10_we = 1'b1; // RL4
               st_nxt.mem_we = st_r.nmi_seen | i_nmi; // RL5
               st_nxt.state  = FSPE_DONE;
            end
         end
         FSPE_DONE:
         begin
            // Return follows the result write so r10 is settled first
            if (i_nmi)
            begin
               st_nxt.nmi_seen = 1'b1;
            end
            st_nxt.ret   = 1'b1; // RL4
            st_nxt.state = FSPE_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         st_r       <= '0;
         st_r.wed   <= `FSPE_RST_WED;
         st_r.spm   <= `FSPE_RST_SPM;
         st_r.state <= FSPE_IDLE;
      end
      else if (i_clk_en)
      begin
         st_r <= st_nxt;
      end
   end

   fspe_settle_cnt u_settle
   (
      .i_mclk   (i_mclk),
      .i_arst_n (i_arst_n),
      .i_clk_en (i_clk_en),
      .i_start  (settle_start),
      .o_busy   (settle_busy)
   );

   // Zero-wait slave; a frozen clock enable holds the access open
   assign o_prdata  = st_r.rdata;
   assign o_pready  = i_clk_en;
   assign o_pslverr = i_psel & i_penable & ~hit;

   assign o_trap_internal = trap_hit & i_clk_en; // RL1
   assign o_trap_ordinary = i_trap_req & ~trap_hit & i_clk_en; // RL2
   // NMIs are swallowed from hand-over to return and show only in the flag
   assign o_nmi_pass      = i_nmi & (st_r.state == FSPE_IDLE) & ~trap_hit; // RL7

   assign o_proc_start = st_r.start;
   assign o_proc_func  = st_r.arg_func;
   assign o_proc_arg2  = st_r.arg_2;
   assign o_proc_arg3  = st_r.arg_3;
   assign o_proc_arg4  = st_r.arg_4;
   assign o_proc_ep    = st_r.arg_ep;

   assign o_r10_we   = st_r.r10_we;
   assign o_r10_data = st_r.result;
   // Bit 7 is only ever set here; clearing it is left to software
   assign o_mem_we   = st_r.mem_we; // RL5
   assign o_mem_addr = st_r.arg_ep + `FSPE_NMI_OFS; // RL5
   assign o_mem_set  = `FSPE_NMI_DATA;
   assign o_return   = st_r.ret;

   assign o_self_prog      = spm_eff;
   assign o_write_erase_en = ~st_r.wed;
   assign o_flash_hold     = settle_busy; // RL20

endmodule // fspe_top

// >>> verification/fspe_sva.sv
// Port-level checks of the self-program entry gate
`timescale 1ns/10ps
module fspe_sva
(
   // Clock, reset and CPU side
   input wire logic        i_mclk, i_arst_n, i_vpp_det, i_trap_req, i_nmi, i_proc_done,
   input wire logic [4:0]  i_trap_vec,
   input wire logic [31:0] i_r6, i_r7, i_r8, i_r9, i_ep, i_proc_result,
   // Design outputs
   input wire logic        o_trap_internal, o_trap_ordinary, o_nmi_pass, o_proc_start, o_r10_we,
   input wire logic        o_mem_we, o_return, o_self_prog, o_write_erase_en, o_flash_hold,
   input wire logic [31:0] o_proc_func, o_proc_arg2, o_proc_arg3, o_proc_arg4, o_proc_ep,
   input wire logic [31:0] o_r10_data, o_mem_addr,
   input wire logic [7:0]  o_mem_set
);
   logic [11:0] hold_cnt_r;
   // Length of the current hold, sampled each cycle
   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         hold_cnt_r <= 12'h000;
      else
         hold_cnt_r <= o_flash_hold ? hold_cnt_r + 12'h001 : 12'h000;
   end
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_arst_n);
   trap_internal_a: assert property (o_trap_internal |-> i_trap_req && i_trap_vec == 5'h1F
      && o_self_prog && o_write_erase_en) else $error("internal trap without mode");
   trap_ordinary_a: assert property (i_trap_req && (i_trap_vec != 5'h1F || !o_self_prog)
      |-> o_trap_ordinary && !o_trap_internal) else $error("trap not ordinary");
   call_args_a: assert property (o_trap_internal |=> o_proc_start && o_proc_func == $past(i_r6)
      && o_proc_ep == $past(i_ep)) else $error("call start or argument wrong");
   more_args_a: assert property (o_proc_start |-> o_proc_arg2 == $past(i_r7)
      && o_proc_arg3 == $past(i_r8) && o_proc_arg4 == $past(i_r9)) else $error("argument wrong");
   result_r10_a: assert property (o_r10_we |-> $past(i_proc_done)
      && o_r10_data == $past(i_proc_result)) else $error("result wrong");
   return_after_a: assert property (o_r10_we |=> o_return) else $error("no return");
   nmi_flag_a: assert property (o_mem_we |-> o_r10_we && o_mem_addr == o_proc_ep + 32'h0000_0004
      && o_mem_set == 8'h80) else $error("flag write wrong");
   nmi_hold_a: assert property ((o_trap_internal || o_proc_start) && i_nmi |-> !o_nmi_pass)
      else $error("nmi passed in hand-over");
   select_vpp_a: assert property (o_self_prog |-> $past(i_vpp_det, 2)) else $error("mode without voltage");
   // A voltage loss starts the hold one cycle after the mode output drops
   settle_start_a: assert property ($fell(o_self_prog) |-> ##[0:1] o_flash_hold) else $error("no hold");
   settle_len_a: assert property ($fell(o_flash_hold) |-> hold_cnt_r == 12'h7D0)
      else $error("hold length wrong");
   cover property (o_trap_internal);
   cover property (o_mem_we);
   cover property ($fell(o_flash_hold));
endmodule // fspe_sva

// >>> verification/fspe_engine_model.sv
// Internal-processing engine model answering each call after a short or long delay
// The calling entry program is taken to run from RAM, outside block 0 and flash
`timescale 1ns/10ps
module fspe_engine_model
(
   // Clock and reset
   input  wire logic        i_mclk,
   input  wire logic        i_arst_n,
   // Call side
   input  wire logic        i_slow,
   input  wire logic        i_start,
   input  wire logic [31:0] i_func,
   // Answer side
   output logic             o_done,
   output logic [31:0]      o_result
);
   logic [5:0]  cnt_r;
   logic [31:0] res_r;
   assign o_done = (cnt_r == 6'h01);
   // Outside done the result shows its inverse so a late sample cannot match
   assign o_result = o_done ? res_r : ~res_r;
   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         cnt_r <= 6'h00;
         res_r <= 32'h0000_0000;
      end
      else if (i_start)
      begin
         cnt_r <= i_slow ? 6'h14 : 6'h02;
         res_r <= i_func ^ 32'hA5A5_0000;
      end
      else if (cnt_r != 6'h00)
         cnt_r <= cnt_r - 6'h01;
   end
endmodule // fspe_engine_model

// >>> verification/testbench.sv
// Bench for the self-program entry gate: APB tasks, trap calls and an engine model
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; $display("wrong value at %0t: %h %h", $time, (a), (b)); end end
module testbench;
   logic        i_mclk = 1'b0, i_arst_n = 1'b0, i_clk_en = 1'b1, i_vpp_det = 1'b1, slow = 1'b0;
   logic        i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0, err;
   logic        i_trap_req = 1'b0, i_int_ack = 1'b0, i_dma_ack = 1'b0, i_nmi = 1'b0;
   logic [4:0]  i_trap_vec = 5'h00;
   logic [7:0]  i_paddr = 8'h00, o_mem_set;
   logic [31:0] i_pwdata = 32'h0, i_r6 = 32'h0, i_r7 = 32'h0, i_r8 = 32'h0, i_r9 = 32'h0, i_ep = 32'h0;
   logic        i_proc_done, o_pready, o_pslverr, o_trap_internal, o_trap_ordinary, o_nmi_pass;
   logic        o_proc_start, o_r10_we, o_mem_we, o_return, o_self_prog, o_write_erase_en, o_flash_hold;
   logic [31:0] i_proc_result, o_prdata, o_proc_func, o_proc_arg2, o_proc_arg3, o_proc_arg4, o_proc_ep;
   logic [31:0] o_r10_data, o_mem_addr, rd, r10_seen, addr_seen;
   int          num_errors = 0, n_checks = 0, mem_cnt = 0, k;
   always #25 i_mclk = ~i_mclk;
   fspe_top u_fspe_top (.*);
   fspe_engine_model u_fspe_engine_model (.i_mclk, .i_arst_n, .i_slow(slow), .i_start(o_proc_start),
      .i_func(o_proc_func), .o_done(i_proc_done), .o_result(i_proc_result));
   always @(posedge i_mclk)
   begin
      if (o_r10_we === 1'b1) r10_seen <= o_r10_data;
      if (o_mem_we === 1'b1) mem_cnt <= mem_cnt + 1;
      if (o_mem_we === 1'b1) addr_seen <= o_mem_addr;
   end
   task automatic report_and_stop();
      if (num_errors == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // One APB transfer; read data and error taken at the completing edge, then one idle cycle
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_mclk);
      i_penable <= 1'b1;
      @(posedge i_mclk);
      while (o_pready !== 1'b1) @(posedge i_mclk);
      rd = o_prdata;
      err = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      @(posedge i_mclk);
   endtask
   // Command write, an optional disturbance, then the mode write
   task automatic mode_wr(input logic [31:0] v, input int how);
      apb(1'b1, 8'h00, v);
      if (how == 1) i_int_ack <= 1'b1;
      if (how == 2) i_dma_ack <= 1'b1;
      if (how == 3) apb(1'b0, 8'h08, 32'h0);
      @(posedge i_mclk);
      i_int_ack <= 1'b0;
      i_dma_ack <= 1'b0;
      apb(1'b1, 8'h04, v);
      repeat (5) @(posedge i_mclk);
   endtask
   task automatic trap(input logic [4:0] v, input logic exp_int);
      i_trap_req <= 1'b1;
      i_trap_vec <= v;
      @(posedge i_mclk);
      `CHK(o_trap_internal, exp_int)
      `CHK(o_trap_ordinary, ~exp_int)
      i_trap_req <= 1'b0;
      @(posedge i_mclk);
   endtask
   task automatic call(input logic [31:0] f, input logic nmi, input logic s);
      i_r6 <= f;
      i_r7 <= f + 32'h1;
      i_r8 <= f + 32'h2;
      i_r9 <= f + 32'h3;
      i_ep <= 32'h2000_0100;
      slow <= s;
      // Flag word cleared and only NMI unmasked before the trap
      @(posedge i_mclk);
      trap(5'h1F, 1'b1);
      i_nmi <= nmi;
      @(posedge i_mclk);
      `CHK(o_nmi_pass, 1'b0)
      i_nmi <= 1'b0;
      for (k = 0; k < 100 && o_return !== 1'b1; k++) @(posedge i_mclk);
      `CHK(o_return, 1'b1)
      `CHK(r10_seen, f ^ 32'hA5A5_0000)
      // All interrupts masked again before the mode register is touched
      @(posedge i_mclk);
   endtask
   initial
   begin
      repeat (3) @(posedge i_mclk);
      i_arst_n <= 1'b1;
      repeat (3) @(posedge i_mclk);
      apb(1'b0, 8'h04, 32'h0);
      `CHK(rd, 32'h0000_001C)
      apb(1'b0, 8'h10, 32'h0);
      `CHK(err, 1'b1)
      trap(5'h1F, 1'b0);
      apb(1'b1, 8'h04, 32'h0000_0012);
      for (int h = 0; h < 4; h++)
      begin
         if (h > 0) mode_wr(32'h0000_0012, h);
         apb(1'b0, 8'h04, 32'h0);
         `CHK(rd, 32'h0000_001C)
      end
      apb(1'b0, 8'h08, 32'h0);
      `CHK(rd[0], 1'b1)
      apb(1'b1, 8'h08, 32'h0000_0001);
      i_vpp_det <= 1'b0;
      repeat (3) @(posedge i_mclk);
      mode_wr(32'h0000_0012, 0);
      apb(1'b0, 8'h04, 32'h0);
      `CHK(rd, 32'h0000_0010)
      i_vpp_det <= 1'b1;
      repeat (3) @(posedge i_mclk);
      mode_wr(32'h0000_0012, 0);
      apb(1'b0, 8'h04, 32'h0);
      `CHK(rd, 32'h0000_0016)
      `CHK(o_write_erase_en, 1'b1)
      trap(5'h1E, 1'b0);
      i_nmi <= 1'b1;
      @(posedge i_mclk);
      `CHK(o_nmi_pass, 1'b1)
      i_nmi <= 1'b0;
      call(32'h0000_0003, 1'b1, 1'b1);
      call(32'h0000_0000, 1'b0, 1'b0);
      `CHK(mem_cnt, 1)
      `CHK(addr_seen, 32'h2000_0104)
      apb(1'b0, 8'h0C, 32'h0);
      `CHK(rd, 32'hA5A5_0000)
      mode_wr(32'h0000_0018, 0);
      `CHK(o_self_prog, 1'b0)
      for (k = 0; k < 3000 && o_flash_hold === 1'b1; k++) @(posedge i_mclk);
      `CHK(k, 2000 - 5)
      report_and_stop();
   end
   initial
   begin
      #(50 * 20000);
      num_errors++;
      report_and_stop();
   end
endmodule // testbench
bind fspe_top fspe_sva u_fspe_sva (.*);
